// ### dv/sdrrs_core_properties.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// port checks for the core
// ----------------------------------------------------------------
module sdrrs_props import sdrrs_pkg::*; (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // link side
   input wire logic temp_hot,
   input wire logic [DQ_W-1:0] dq,
   input wire logic dq_oe,
   input wire logic dqs,
   input wire logic dqs_n,
   input wire logic dqs_oe,
   input wire logic sr_auto_active,
   input wire logic sr_rate_ext
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // temperature input must settle past its synchroniser before judging
   logic temp_prev_q;
   logic [2:0] temp_cnt_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_prev_q <= 1'b0;
         temp_cnt_q <= 3'h0;
      end else begin
         temp_prev_q <= temp_hot;
         temp_cnt_q <= (temp_hot != temp_prev_q) ? 3'h0 :
                       ((temp_cnt_q == 3'h7) ? 3'h7 : temp_cnt_q + 3'h1);
      end
   end

   a_ready_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("apb answer not after one wait state");
   a_ready_single: assert property (pready |=> !pready)
      else $error("apb ready longer than one cycle");
   a_err_refused: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("apb error without ready or with data");
   a_auto_temp: assert property (sr_auto_active && $past(sr_auto_active) && temp_cnt_q >= 3'h4
      |-> sr_rate_ext == temp_hot) else $error("auto rate does not follow temperature");
   a_strobe_pair: assert property (dqs_oe |-> dqs_n == !dqs)
      else $error("strobe pair not complementary");
   a_data_strobe_en: assert property (dq_oe |-> dqs_oe)
      else $error("data driven without strobe");
   a_beat_strobe: assert property (dq_oe && $changed(dq) |-> $changed(dqs))
      else $error("data moved without strobe edge");
   a_strobe_hold: assert property (dq_oe && $changed(dqs) |=> $stable(dqs)[*4])
      else $error("strobe half period too short");
   a_rise_to_fall: assert property (dq_oe && $rose(dqs) |-> ##[5:8] $fell(dqs))
      else $error("strobe did not fall within half link cycle");
   a_read_preamble: assert property ($rose(dq_oe) |-> dqs && $past(dqs_oe, 4) && !$past(dq_oe, 4))
      else $error("first beat without preamble");
endmodule : sdrrs_props

bind sdrrs_core sdrrs_props u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .temp_hot(temp_hot), .dq(dq), .dq_oe(dq_oe),
   .dqs(dqs), .dqs_n(dqs_n), .dqs_oe(dqs_oe), .sr_auto_active(sr_auto_active),
   .sr_rate_ext(sr_rate_ext)
);

// ### dv/sdrrs_core_test.sv
`timescale 1ns/1ns
module sdrrs_core_test import sdrrs_pkg::*; ;
   localparam logic [3:0] C_MRS = 4'h0;
   localparam logic [3:0] C_ACT = 4'h3;
   localparam logic [3:0] C_PRE = 4'h2;
   localparam logic [3:0] C_RD = 4'h5;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, temp_hot;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic link_ck, cs_n, ras_n, cas_n, we_n, err, a12, ap;
   logic [BA_W-1:0] ba, b;
   logic [ROW_W-1:0] addr, row;
   logic [DQ_W-1:0] dq;
   logic dq_oe, dqs, dqs_n, dqs_oe, sr_auto_active, sr_rate_ext;
   logic [1:0] f;
   logic [9:0] col;
   int miscompares, check_count, cycles, rl;
   integer seed;

   sdrrs_core dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_ck(link_ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
      .addr(addr), .temp_hot(temp_hot), .dq(dq), .dq_oe(dq_oe), .dqs(dqs), .dqs_n(dqs_n),
      .dqs_oe(dqs_oe), .sr_auto_active(sr_auto_active), .sr_rate_ext(sr_rate_ext)
   );
   sdrrs_ctl_model ctl (
      .link_ck(link_ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
      .addr(addr)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [15:0] exp_beat(logic [12:0] r, logic [9:0] c, logic [2:0] k);
      return {r, 3'h0} ^ {6'h0, c[9:3], c[2:0] + k};
   endfunction : exp_beat

   function automatic int nbeats(logic [1:0] fld, logic bit12);
      return (fld == BURST_FIXED4 || (fld == BURST_OTF && !bit12)) ? 4 : 8;
   endfunction : nbeats

   // samples 44 ns after each link edge, clear of the pclk edges
   task automatic rdcheck(input int nb);
      ctl.cmd(C_RD, b, {a12, 1'b0, ap, col});
      repeat (rl) @(posedge link_ck);
      for (int k = 0; k < nb; k++) begin
         #44;
         chk(32'(dq_oe), 32'h1);
         chk(32'(dq), 32'(exp_beat(row, col, 3'(k))));
         chk(32'(dqs), 32'(k % 2 == 0));
         @(link_ck);
      end
      #44;
      chk(32'(dq_oe), 32'h0);
   endtask : rdcheck

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'he10f;
      {presetn, psel, penable, pwrite, temp_hot} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      {miscompares, check_count, cycles} = 0;
      rl = 5;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, {23'h0, AL_RST, CL_RST, DLL_RST});
      apb(1'b1, 8'h10, 32'hffff_ffff);
      chk({31'h0, err}, 32'h1);
      $display("register test done");
      for (int m = 0; m < 4; m++) begin
         @(posedge pclk);
         temp_hot <= 1'($random(seed));
         ctl.cmd(C_MRS, MR2_SEL, 13'(m) << MR_ASEL_BIT);
         repeat (6) @(posedge pclk);
         chk(32'(sr_auto_active), 32'(m == 1));
         chk(32'(sr_rate_ext), 32'((m == 1) ? temp_hot : m[1]));
         apb(1'b0, STATUS_OFS, 32'h0);
         chk(32'(rd[ST_ILLEGAL_BIT]), 32'(m == 3));
      end
      $display("self-refresh mode test done");
      for (int i = 0; i < 8; i++) begin
         f = 2'(i);
         b = 3'($random(seed));
         row = 13'($random(seed));
         col = 10'($random(seed));
         a12 = 1'($random(seed));
         ap = (i > 5);
         if (i == 4) begin
            apb(1'b1, CTRL_OFS, 32'h0000_008b);
            rl = 9;
         end
         ctl.cmd(C_MRS, MR0_SEL, 13'(f));
         apb(1'b0, STATUS_OFS, 32'h0);
         chk(32'(rd[5:4]), 32'(f));
         ctl.cmd(C_ACT, b, row);
         apb(1'b0, ROW_BASE_OFS + {3'h0, b, 2'h0}, 32'h0);
         chk(rd, 32'(row));
         rdcheck(nbeats(f, a12));
         apb(1'b0, BANK_OFS, 32'h0);
         chk(32'(rd[BANK_OPEN_LSB + b]), 32'(!ap));
         ctl.cmd(C_PRE, b, 13'h0);
         apb(1'b0, BANK_OFS, 32'h0);
         chk(32'(rd[BANK_PRE_LSB + b]), 32'h1);
         chk(32'(rd[BANK_OPEN_LSB + b]), 32'h0);
      end
      $display("read burst test done");
      ctl.cmd(C_PRE, b, 13'h0);
      ctl.cmd(C_PRE, b, 13'h0);
      repeat (3) @(posedge link_ck);
      apb(1'b0, BANK_OFS, 32'h0);
      chk(32'(rd[BANK_PRE_LSB + b]), 32'h1);
      repeat (4) @(posedge link_ck);
      apb(1'b0, BANK_OFS, 32'h0);
      chk(32'(rd[15:8]), 32'h0);
      // deliberate read to an idle bank
      ctl.cmd(C_RD, b, 13'h0);
      repeat (3) @(posedge link_ck);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(32'(rd[ST_IDLE_ERR_BIT]), 32'h1);
      apb(1'b1, STATUS_OFS, 32'h8);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(32'(rd[ST_IDLE_ERR_BIT]), 32'h0);
      ctl.cmd(C_ACT, b, row);
      ctl.cmd(C_PRE, ~b, 13'h0400);
      apb(1'b0, BANK_OFS, 32'h0);
      chk(32'(rd[7:0]), 32'h0);
      $display("precharge test done");
      end_of_test();
   end
endmodule : sdrrs_core_test

// ### dv/sdrrs_ctl_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// memory controller: free running link clock, commands on falls
// ----------------------------------------------------------------
module sdrrs_ctl_model import sdrrs_pkg::*; (
   // link clock and command pins
   output logic link_ck,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [BA_W-1:0] ba,
   output logic [ROW_W-1:0] addr
);
   initial begin
      link_ck = 1'b0;
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      ba = 3'h0;
      addr = 13'h0;
      forever begin
         #63 link_ck = 1'b1;
         #62 link_ck = 1'b0;
      end
   end

   // pins change on the fall so they are steady around the rise
   task automatic cmd(input logic [3:0] c, input logic [BA_W-1:0] b, input logic [ROW_W-1:0] a);
      if (c == 4'h3) repeat (TRP_CK) @(posedge link_ck);
      @(negedge link_ck);
      {cs_n, ras_n, cas_n, we_n} = c;
      ba = b;
      addr = a;
      @(negedge link_ck);
      // don't-care lines never keep the last value
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      ba = ~b;
      addr = ~a;
   endtask : cmd
endmodule : sdrrs_ctl_model

// ### pkg/sdrrs_pkg.sv
package sdrrs_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int NBANK = 8;
   localparam int BA_W = 3;
   localparam int ROW_W = 13;
   localparam int COL_W = 10;
   localparam int DQ_W = 16;
   localparam int PIN_W = 4 + BA_W + ROW_W;
   localparam int NSLOT = 32;
   localparam int SLOT_W = 5;

   // ----------------------------------------------------------------
   // apb register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] BANK_OFS = 8'h08;
   localparam logic [7:0] ROW_BASE_OFS = 8'h20;
   localparam logic [7:0] ROW_LAST_OFS = 8'h3c;

   // ctrl fields and reset values
   localparam int CTRL_DLL_BIT = 0;
   localparam int CTRL_CL_LSB = 1;
   localparam int CTRL_AL_LSB = 5;
   localparam logic DLL_RST = 1'b1;
   localparam logic [3:0] CL_RST = 4'h5;
   localparam logic [3:0] AL_RST = 4'h0;

   // status fields
   localparam int ST_AUTO_BIT = 0;
   localparam int ST_EXT_BIT = 1;
   localparam int ST_ILLEGAL_BIT = 2;
   localparam int ST_IDLE_ERR_BIT = 3;
   localparam int ST_BURST_LSB = 4;
   localparam int ST_ASEL_BIT = 6;
   localparam int ST_RSEL_BIT = 7;
   localparam int ST_DLL_BIT = 8;

   // bank register fields
   localparam int BANK_OPEN_LSB = 0;
   localparam int BANK_PRE_LSB = 8;

   // ----------------------------------------------------------------
   // mode register and address-pin fields
   // ----------------------------------------------------------------
   localparam logic [BA_W-1:0] MR0_SEL = 3'h0;
   localparam logic [BA_W-1:0] MR2_SEL = 3'h2;
   localparam int MR_ASEL_BIT = 6;
   localparam int MR_RSEL_BIT = 7;
   localparam int AP_BIT = 10;
   localparam int BC_BIT = 12;
   localparam logic [1:0] BURST_FIXED8 = 2'h0;
   localparam logic [1:0] BURST_OTF = 2'h1;
   localparam logic [1:0] BURST_FIXED4 = 2'h2;
   localparam logic [2:0] LAST_BEAT_BL8 = 3'h7;
   localparam logic [2:0] LAST_BEAT_BC4 = 3'h3;

   // precharge period in link clock cycles
   localparam logic [3:0] TRP_CK = 4'h4;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_NOP, CMD_MRS, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR
   } sdrrs_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE, ST_PREAMBLE, ST_BURST, ST_POST
   } sdrrs_state_t;

   typedef struct packed {
      logic vld;
      logic full_burst_eight;
      logic ap;
      logic [BA_W-1:0] bank;
      logic [COL_W-1:0] col;
   } sdrrs_slot_t;

endpackage : sdrrs_pkg

// ### verilog/sdrrs_core.sv
// Summary of operation
// - auto mode only with select=1, range=0
// - auto mode: rate follows operating temperature
// - range zero, select zero: normal-temperature self-refresh rate
// - range one: extended-capable self-refresh rate
// - activate opens addressed row in selected bank
// - precharge closes one or all banks
// - other-bank reads allowed during auto-precharge
// - repeat precharge accepted, last restarts period
// - address bit 12 picks chopped or full burst in mode field 01
// - address bit 12 never a column bit
// - mode field 00 or 11, or 01 with bit12, gives eight
// - read data starts additive plus cas latency later
// - data and toggling strobe with dll enabled
`timescale 1ns/1ns
module sdrrs_core import sdrrs_pkg::*; (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link clock and command pins
   input wire logic link_ck,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [BA_W-1:0] ba,
   input wire logic [ROW_W-1:0] addr,
   // case temperature above normal range
   input wire logic temp_hot,
   // read data and strobe
   output logic [DQ_W-1:0] dq,
   output logic dq_oe,
   output logic dqs,
   output logic dqs_n,
   output logic dqs_oe,
   // self-refresh rate selection
   output logic sr_auto_active,
   output logic sr_rate_ext
);

   typedef struct packed {
      logic ck_s1;
      logic ck_s2;
      logic ck_s3;
      logic [PIN_W-1:0] pin_s1;
      logic [PIN_W-1:0] pin_s2;
      logic temp_s1;
      logic temp_s2;
      logic [1:0] burst_field;
      logic auto_selfrefresh_sel;
      logic selfrefresh_range_sel;
      logic dll_en;
      logic [3:0] cl;
      logic [3:0] al;
      logic idle_err;
      logic [NBANK-1:0] open_mask;
      logic [NBANK-1:0][3:0] pre_cnt;
      sdrrs_slot_t [NSLOT-1:0] slots;
      sdrrs_state_t st;
      logic [2:0] beat;
      logic [2:0] last_beat;
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
      logic [DQ_W-1:0] dq;
      logic dq_oe;
      logic dqs;
      logic dqs_n;
      logic dqs_oe;
      logic sr_auto;
      logic sr_ext;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } sdrrs_regs_t;

   sdrrs_regs_t q;
   sdrrs_regs_t d;

   // ----------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------
   function automatic sdrrs_cmd_t decode_cmd(input logic [3:0] ctl);
      sdrrs_cmd_t c;
      c = CMD_NOP;
      case (ctl)
         4'h0: c = CMD_MRS;
         4'h3: c = CMD_ACT;
         4'h2: c = CMD_PRE;
         4'h5: c = CMD_RD;
         4'h4: c = CMD_WR;
         default: c = CMD_NOP;
      endcase
      return c;
   endfunction : decode_cmd

   function automatic logic is_mapped(input logic [7:0] a);
      logic m;
      m = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == BANK_OFS) ||
          ((a >= ROW_BASE_OFS) && (a <= ROW_LAST_OFS) && (a[1:0] == 2'h0));
      return m;
   endfunction : is_mapped

   // sequential burst order within the aligned group of eight
   function automatic logic [DQ_W-1:0] beat_data(input logic [ROW_W-1:0] r,
                                                 input logic [COL_W-1:0] c,
                                                 input logic [2:0] b);
      logic [2:0] lo;
      lo = c[2:0] + b;
      return {r, 3'h0} ^ {6'h0, c[COL_W-1:3], lo};
   endfunction : beat_data

   // ----------------------------------------------------------------
   // row memory
   // ----------------------------------------------------------------
   logic mem_we;
   logic [BA_W-1:0] mem_wbank;
   logic [ROW_W-1:0] mem_wrow;
   logic [ROW_W-1:0] row_a;
   logic [ROW_W-1:0] row_b;

   sdrrs_rowmem u_rowmem (
      .pclk(pclk),
      .presetn(presetn),
      .we(mem_we),
      .waddr(mem_wbank),
      .wdata(mem_wrow),
      .raddr_a(q.slots[0].bank),
      .rdata_a(row_a),
      .raddr_b(paddr[4:2]),
      .rdata_b(row_b)
   );

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   logic rise;
   logic fall;
   logic acc;
   sdrrs_cmd_t cmd;
   logic [BA_W-1:0] cba;
   logic [ROW_W-1:0] caddr;
   logic [SLOT_W-1:0] rl;
   logic [SLOT_W-1:0] ins;
   sdrrs_slot_t nslot;

   always_comb begin
      d = q;
      rise = q.ck_s2 & ~q.ck_s3;
      fall = ~q.ck_s2 & q.ck_s3;
      acc = psel & penable;
      cmd = decode_cmd(q.pin_s2[PIN_W-1 -: 4]);
      cba = q.pin_s2[ROW_W +: BA_W];
      caddr = q.pin_s2[ROW_W-1:0];
      rl = SLOT_W'(q.al) + SLOT_W'(q.cl);
      ins = (rl == '0) ? '0 : rl - SLOT_W'(1);
      nslot = '0;
      mem_we = 1'b0;
      mem_wbank = cba;
      mem_wrow = caddr;

      // pins cross into pclk through two flops and only stage two is read; link_ck gets a third flop for edge detection
      d.ck_s1 = link_ck;
      d.ck_s2 = q.ck_s1;
      d.ck_s3 = q.ck_s2;
      d.pin_s1 = {cs_n, ras_n, cas_n, we_n, ba, addr};
      d.pin_s2 = q.pin_s1;
      d.temp_s1 = temp_hot;
      d.temp_s2 = q.temp_s1;

      // ----------------------------------------------------------------
      // self-refresh rate selection
      // ----------------------------------------------------------------
      d.sr_auto = q.auto_selfrefresh_sel & ~q.selfrefresh_range_sel;
      // auto mode picks the rate itself from temperature
      if (d.sr_auto) begin
         d.sr_ext = q.temp_s2;
      end else begin
         // an illegal both-set code falls here and stays on the safe rate
         d.sr_ext = q.selfrefresh_range_sel;
      end

      // ----------------------------------------------------------------
      // apb access: one wait state so row reads come from a register
      // ----------------------------------------------------------------
      d.pready = acc & ~q.pready;
      // answer fields stand only in the ready cycle
      d.pslverr = 1'b0;
      d.prdata = '0;
      if (acc & ~q.pready) begin
         d.pslverr = ~is_mapped(paddr);
         d.prdata = '0;
         case (paddr)
            CTRL_OFS: begin
               d.prdata[CTRL_DLL_BIT] = q.dll_en;
               d.prdata[CTRL_CL_LSB +: 4] = q.cl;
               d.prdata[CTRL_AL_LSB +: 4] = q.al;
            end
            STATUS_OFS: begin
               d.prdata[ST_AUTO_BIT] = q.sr_auto;
               d.prdata[ST_EXT_BIT] = q.sr_ext;
               d.prdata[ST_ILLEGAL_BIT] = q.auto_selfrefresh_sel & q.selfrefresh_range_sel;
               d.prdata[ST_IDLE_ERR_BIT] = q.idle_err;
               d.prdata[ST_BURST_LSB +: 2] = q.burst_field;
               d.prdata[ST_ASEL_BIT] = q.auto_selfrefresh_sel;
               d.prdata[ST_RSEL_BIT] = q.selfrefresh_range_sel;
               d.prdata[ST_DLL_BIT] = q.dll_en;
            end
            BANK_OFS: begin
               d.prdata[BANK_OPEN_LSB +: NBANK] = q.open_mask;
               for (int i = 0; i < NBANK; i++) begin
                  d.prdata[BANK_PRE_LSB + i] = (q.pre_cnt[i] != 4'h0);
               end
            end
            default: begin
               if (is_mapped(paddr)) begin
                  d.prdata[ROW_W-1:0] = row_b;
               end
            end
         endcase
      end
      // writes take effect only at the handshake edge
      if (acc & q.pready & pwrite & is_mapped(paddr)) begin
         if (paddr == CTRL_OFS) begin
            d.dll_en = pwdata[CTRL_DLL_BIT];
            d.cl = pwdata[CTRL_CL_LSB +: 4];
            d.al = pwdata[CTRL_AL_LSB +: 4];
         end
         if ((paddr == STATUS_OFS) && pwdata[ST_IDLE_ERR_BIT]) begin
            d.idle_err = 1'b0;
         end
      end

      // ----------------------------------------------------------------
      // command pipe on each link rising edge
      // ----------------------------------------------------------------
      if (rise) begin
         for (int i = 0; i < NBANK; i++) begin
            if (q.pre_cnt[i] != 4'h0) begin
               d.pre_cnt[i] = q.pre_cnt[i] - 4'h1;
            end
         end
         for (int i = 0; i < NSLOT - 1; i++) begin
            d.slots[i] = q.slots[i + 1];
         end
         d.slots[NSLOT-1] = '0;

         case (cmd)
            CMD_MRS: begin
               if (cba == MR0_SEL) begin
                  d.burst_field = caddr[1:0];
               end
               if (cba == MR2_SEL) begin
                  d.auto_selfrefresh_sel = caddr[MR_ASEL_BIT];
                  d.selfrefresh_range_sel = caddr[MR_RSEL_BIT];
               end
            end
            CMD_ACT: begin
               d.open_mask[cba] = 1'b1;
               mem_we = 1'b1;
            end
            CMD_PRE: begin
               for (int i = 0; i < NBANK; i++) begin
                  // restart even if idle or already precharging
                  if (caddr[AP_BIT] || (cba == BA_W'(i))) begin
                     d.open_mask[i] = 1'b0;
                     d.pre_cnt[i] = TRP_CK;
                  end
               end
            end
            CMD_RD: begin
               if (q.open_mask[cba]) begin
                  nslot.vld = 1'b1;
                  nslot.ap = caddr[AP_BIT];
                  nslot.bank = cba;
                  nslot.col = caddr[COL_W-1:0];
                  case (q.burst_field)
                     BURST_FIXED8: nslot.full_burst_eight = 1'b1;
                     BURST_OTF: nslot.full_burst_eight = caddr[BC_BIT];
                     BURST_FIXED4: nslot.full_burst_eight = 1'b0;
                     default: nslot.full_burst_eight = 1'b1;
                  endcase
                  d.slots[ins] = nslot;
               end else begin
                  // read to an idle bank returns nothing
                  d.idle_err = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // ----------------------------------------------------------------
      // read burst on both link edges
      // ----------------------------------------------------------------
      if (rise || fall) begin
         case (q.st)
            ST_BURST: begin
               // last beat always falls on a falling edge
               if (q.beat == q.last_beat) begin
                  d.st = ST_POST;
                  d.dq_oe = 1'b0;
                  d.dqs = 1'b0;
                  d.dqs_n = 1'b1;
               end else begin
                  d.beat = q.beat + 3'h1;
                  d.dq = beat_data(q.row, q.col, d.beat);
                  d.dqs = rise;
                  d.dqs_n = ~rise;
               end
            end
            ST_POST: begin
               if (fall) begin
                  d.st = ST_IDLE;
                  d.dqs_oe = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // slot zero at a rising edge is exactly the read latency after the read
      if (rise && q.slots[0].vld && q.dll_en) begin
         d.st = ST_BURST;
         d.beat = 3'h0;
         d.last_beat = q.slots[0].full_burst_eight ? LAST_BEAT_BL8 : LAST_BEAT_BC4;
         d.row = row_a;
         d.col = q.slots[0].col;
         d.dq = beat_data(row_a, q.slots[0].col, 3'h0);
         d.dq_oe = 1'b1;
         d.dqs = 1'b1;
         d.dqs_n = 1'b0;
         d.dqs_oe = 1'b1;
         // auto-precharge closes only this bank; others keep serving reads
         if (q.slots[0].ap) begin
            d.open_mask[q.slots[0].bank] = 1'b0;
            d.pre_cnt[q.slots[0].bank] = TRP_CK;
         end
      end

      // strobe preamble one link cycle before the first beat
      if (rise && (d.st != ST_BURST) && d.slots[0].vld && q.dll_en) begin
         d.st = ST_PREAMBLE;
         d.dq_oe = 1'b0;
         d.dqs = 1'b0;
         d.dqs_n = 1'b1;
         d.dqs_oe = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.dll_en <= DLL_RST;
         q.cl <= CL_RST;
         q.al <= AL_RST;
         q.st <= ST_IDLE;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign dq = q.dq;
   assign dq_oe = q.dq_oe;
   assign dqs = q.dqs;
   assign dqs_n = q.dqs_n;
   assign dqs_oe = q.dqs_oe;
   assign sr_auto_active = q.sr_auto;
   assign sr_rate_ext = q.sr_ext;

endmodule : sdrrs_core

// ### verilog/sdrrs_rowmem.sv
`timescale 1ns/1ns
module sdrrs_rowmem import sdrrs_pkg::*; (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write port
   input wire logic we,
   input wire logic [BA_W-1:0] waddr,
   input wire logic [ROW_W-1:0] wdata,
   // read port a
   input wire logic [BA_W-1:0] raddr_a,
   output logic [ROW_W-1:0] rdata_a,
   // read port b
   input wire logic [BA_W-1:0] raddr_b,
   output logic [ROW_W-1:0] rdata_b
);

   typedef struct packed {
      logic [NBANK-1:0][ROW_W-1:0] mem;
      logic [ROW_W-1:0] ra;
      logic [ROW_W-1:0] rb;
   } sdrrs_mem_t;

   sdrrs_mem_t q;
   sdrrs_mem_t d;

   // read data is registered; a write shows on a read one cycle later
   always_comb begin
      d = q;
      d.ra = q.mem[raddr_a];
      d.rb = q.mem[raddr_b];
      if (we) begin
         d.mem[waddr] = wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rdata_a = q.ra;
   assign rdata_b = q.rb;

endmodule : sdrrs_rowmem
